// File: rtl/dds_output_framing_events.sv
// output packing, side-band framing and error events of a multichannel synthesizer
// Operation
// - quadrature: sign-extend both to bytes, cosine low, sine above
// - single sample: sign-extend to byte boundary, placed at low end
// - side-band with user and channel index: index in lowest bits
// - user field passes uninterpreted, delayed like the datapath
// - vector framing: frame end on last channel of each cycle
// - packet framing: input frame end forwarded with datapath latency
// - config framing: frame end on last old-settings channel before change
// - conventional: phase output sign-extended to multiple of 8 bits
// - rasterized: phase output zero-extended to multiple of 8 bits
// - phase output side-band options independent, same layout
// - phase output uses the sample output frame-end behaviour
// - events cleared by reset, asserted for every discrepant cycle
// - config stream: early frame end or missing last marker flagged
// - phase stream, vector input framing: early frame end or missing last marker flagged
// - rasterized: out-of-range increment or offset raises an event
// - channel index differing from internal counter raises an event
// - one to 16 channels, one per clock in rotation
// - channel index field is minimum width for the channel count
//
// The APB slave port and the address map were decided locally.
module dds_output_framing_events #(
	parameter int MAX_CH = 16,
	parameter int PHASE_W = 11,
	parameter int OUT_W = 11,
	parameter int USER_W = 8,
	parameter int LAT = 4
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// configuration stream
	input wire logic i_cfg_tvalid,
	input wire logic i_cfg_tlast,
	input wire logic [2*(((PHASE_W+7)/8)*8)-1:0] i_cfg_tdata,
	output logic o_cfg_tready,
	output logic o_cfg_apply,
	// phase input stream
	input wire logic i_phs_tvalid,
	input wire logic i_phs_tlast,
	input wire logic [2*(((PHASE_W+7)/8)*8)-1:0] i_phs_tdata,
	input wire logic [USER_W+$clog2(MAX_CH)-1:0] i_phs_tuser,
	// datapath results, valid LAT cycles after the phase input
	input wire logic i_dp_valid,
	input wire logic [OUT_W-1:0] i_sine,
	input wire logic [OUT_W-1:0] i_cosine,
	input wire logic [PHASE_W-1:0] i_phase_out,
	// sample output stream
	output logic o_dat_tvalid,
	output logic o_dat_tlast,
	output logic [2*(((OUT_W+7)/8)*8)-1:0] o_dat_tdata,
	output logic [USER_W+$clog2(MAX_CH)-1:0] o_dat_tuser,
	// phase output stream
	output logic o_pho_tvalid,
	output logic o_pho_tlast,
	output logic [((PHASE_W+7)/8)*8-1:0] o_pho_tdata,
	output logic [USER_W+$clog2(MAX_CH)-1:0] o_pho_tuser,
	// events
	output logic o_ev_cfg_last_unexp,
	output logic o_ev_cfg_last_miss,
	output logic o_ev_phs_last_unexp,
	output logic o_ev_phs_last_miss,
	output logic o_ev_pinc_invalid,
	output logic o_ev_poff_invalid,
	output logic o_ev_chanid_wrong
);
	localparam int CW = $clog2(MAX_CH);
	localparam int PB = ((PHASE_W + 7) / 8) * 8;
	localparam int OB = ((OUT_W + 7) / 8) * 8;
	localparam int TUW = USER_W + CW;

	////////////////////////////////////////////////////////////////////////
	// register file
	logic [31:0] ctrl_ff;
	logic [31:0] nxt_ctrl;
	logic [PHASE_W-1:0] modulus_ff;
	logic [PHASE_W-1:0] nxt_modulus;
	dds_framing_pkg::apb_state_type apb_ff;
	dds_framing_pkg::apb_state_type nxt_apb;
	logic [31:0] nxt_prdata;
	wire hit_ctrl;
	wire hit_mod;
	wire hit_stat;
	wire mapped;
	wire wr_take;
	wire [31:0] status_word;

	// address decode
	assign hit_ctrl = (i_paddr == dds_framing_pkg::CTRL_ADDR);
	assign hit_mod = (i_paddr == dds_framing_pkg::MODULUS_ADDR);
	assign hit_stat = (i_paddr == dds_framing_pkg::STATUS_ADDR);
	assign mapped = hit_ctrl | hit_mod | hit_stat;
	assign nxt_apb = (i_psel & i_penable & (apb_ff == dds_framing_pkg::APB_IDLE)) ?
		dds_framing_pkg::APB_DONE : dds_framing_pkg::APB_IDLE;
	// write lands at the completing edge, where pready is seen high
	assign wr_take = i_psel & i_penable & i_pwrite & (apb_ff == dds_framing_pkg::APB_DONE);
	assign nxt_ctrl = (wr_take & hit_ctrl) ? i_pwdata : ctrl_ff;
	assign nxt_modulus = (wr_take & hit_mod) ? i_pwdata[PHASE_W-1:0] : modulus_ff;

	// control fields
	wire [1:0] osel = ctrl_ff[dds_framing_pkg::CTRL_OSEL_LSB +: 2];
	wire [1:0] oframe = ctrl_ff[dds_framing_pkg::CTRL_OFRAME_LSB +: 2];
	wire [1:0] iframe = ctrl_ff[dds_framing_pkg::CTRL_IFRAME_LSB +: 2];
	wire raster = ctrl_ff[dds_framing_pkg::CTRL_RASTER_BIT];
	wire [CW-1:0] last_ch = ctrl_ff[dds_framing_pkg::CTRL_LASTCH_LSB +: CW];

	// read data, unmapped reads zero
	always_comb begin
		if (hit_ctrl) begin
			nxt_prdata = ctrl_ff;
		end else if (hit_mod) begin
			nxt_prdata = {{(32-PHASE_W){1'b0}}, modulus_ff};
		end else if (hit_stat) begin
			nxt_prdata = status_word;
		end else begin
			nxt_prdata = 32'h0000_0000;
		end
	end

	// apb registers
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			apb_ff <= dds_framing_pkg::APB_IDLE;
			ctrl_ff <= dds_framing_pkg::CTRL_RESET;
			modulus_ff <= dds_framing_pkg::MODULUS_RESET[PHASE_W-1:0];
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h0000_0000;
		end else begin
			apb_ff <= nxt_apb;
			ctrl_ff <= nxt_ctrl;
			modulus_ff <= nxt_modulus;
			o_pready <= (nxt_apb == dds_framing_pkg::APB_DONE);
			o_pslverr <= (nxt_apb == dds_framing_pkg::APB_DONE) & ~mapped;
			o_prdata <= (nxt_apb == dds_framing_pkg::APB_DONE) ? nxt_prdata : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// channel counters and configuration hand-over
	logic [CW-1:0] ch_ff;
	logic [CW-1:0] cfg_ch_ff;
	logic pend_ff;
	wire multi = (last_ch != '0);
	wire ch_end = (ch_ff == last_ch);
	wire cfg_end = (cfg_ch_ff == last_ch);
	wire [CW-1:0] nxt_ch = (i_phs_tvalid) ? (ch_end ? '0 : ch_ff + 1'b1) : ch_ff;
	wire cfg_restart = cfg_end | (multi & i_cfg_tlast);
	wire [CW-1:0] nxt_cfg_ch = (i_cfg_tvalid) ? (cfg_restart ? '0 : cfg_ch_ff + 1'b1) :
		cfg_ch_ff;
	wire cfg_done = i_cfg_tvalid & cfg_end;
	// sync point: packet end in packet mode, counter rollover otherwise
	wire sync = i_phs_tvalid & ((iframe == dds_framing_pkg::FRAME_PACKET) ? i_phs_tlast : ch_end);
	wire apply = sync & pend_ff;
	wire nxt_pend = cfg_done | (pend_ff & ~sync); // completion wins over the hand-over

	// counter registers
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ch_ff <= '0;
			cfg_ch_ff <= '0;
			pend_ff <= 1'b0;
			o_cfg_apply <= 1'b0;
			o_cfg_tready <= 1'b0;
		end else begin
			ch_ff <= nxt_ch;
			cfg_ch_ff <= nxt_cfg_ch;
			pend_ff <= nxt_pend;
			o_cfg_apply <= apply;
			o_cfg_tready <= 1'b1; // config stream never stalls
		end
	end

	////////////////////////////////////////////////////////////////////////
	// error events
	wire [PHASE_W-1:0] in_pinc = i_phs_tdata[PHASE_W-1:0];
	wire [PHASE_W-1:0] in_poff = i_phs_tdata[PB +: PHASE_W];
	wire [PHASE_W-1:0] cf_pinc = i_cfg_tdata[PHASE_W-1:0];
	wire [PHASE_W-1:0] cf_poff = i_cfg_tdata[PB +: PHASE_W];
	wire ev_cu = multi & i_cfg_tvalid & i_cfg_tlast & ~cfg_end;
	wire ev_cm = multi & i_cfg_tvalid & ~i_cfg_tlast & cfg_end;
	wire phs_vec = multi & (iframe == dds_framing_pkg::FRAME_VECTOR) & i_phs_tvalid;
	wire ev_pu = phs_vec & i_phs_tlast & ~ch_end;
	wire ev_pm = phs_vec & ~i_phs_tlast & ch_end;
	wire ev_pi = raster & ((i_phs_tvalid & (in_pinc >= modulus_ff)) |
		(i_cfg_tvalid & (cf_pinc >= modulus_ff)));
	wire ev_po = raster & ((i_phs_tvalid & (in_poff >= modulus_ff)) |
		(i_cfg_tvalid & (cf_poff >= modulus_ff)));
	wire ev_id = ctrl_ff[dds_framing_pkg::CTRL_ICHAN_BIT] & i_phs_tvalid &
		(i_phs_tuser[CW-1:0] != ch_ff);

	// event flops, one per discrepant cycle
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_ev_cfg_last_unexp <= 1'b0;
			o_ev_cfg_last_miss <= 1'b0;
			o_ev_phs_last_unexp <= 1'b0;
			o_ev_phs_last_miss <= 1'b0;
			o_ev_pinc_invalid <= 1'b0;
			o_ev_poff_invalid <= 1'b0;
			o_ev_chanid_wrong <= 1'b0;
		end else begin
			o_ev_cfg_last_unexp <= ev_cu;
			o_ev_cfg_last_miss <= ev_cm;
			o_ev_phs_last_unexp <= ev_pu;
			o_ev_phs_last_miss <= ev_pm;
			o_ev_pinc_invalid <= ev_pi;
			o_ev_poff_invalid <= ev_po;
			o_ev_chanid_wrong <= ev_id;
		end
	end

	// status fields placed by shift, no zero-width padding when the index is 4 bits
	assign status_word = (32'(ch_ff) << dds_framing_pkg::STAT_CH_LSB) |
		(32'(cfg_ch_ff) << dds_framing_pkg::STAT_CFGCH_LSB) |
		(32'(pend_ff) << dds_framing_pkg::STAT_PEND_BIT) |
		(32'({o_ev_chanid_wrong, o_ev_poff_invalid, o_ev_pinc_invalid, o_ev_phs_last_miss,
		o_ev_phs_last_unexp, o_ev_cfg_last_miss, o_ev_cfg_last_unexp}) <<
		dds_framing_pkg::STAT_EV_LSB);

	////////////////////////////////////////////////////////////////////////
	// side-band delay line matching the datapath latency
	wire in_last;
	logic [USER_W-1:0] dl_user[LAT+1];
	logic [CW-1:0] dl_chan[LAT+1];
	logic dl_last[LAT+1];

	// frame-end marker chosen at the input, travels with the sample
	assign in_last = (oframe == dds_framing_pkg::FRAME_VECTOR) ? (i_phs_tvalid & ch_end) :
		(oframe == dds_framing_pkg::FRAME_PACKET) ? (i_phs_tvalid & i_phs_tlast) :
		(oframe == dds_framing_pkg::FRAME_CONFIG) ? apply : 1'b0;
	assign dl_user[0] = i_phs_tuser[CW +: USER_W];
	assign dl_chan[0] = ch_ff;
	assign dl_last[0] = in_last;

	genvar g;
	generate
		for (g = 0; g < LAT; g++) begin : g_dl
			// one pipeline stage of side-band fields
			always_ff @(posedge i_clk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					dl_user[g+1] <= '0;
					dl_chan[g+1] <= '0;
					dl_last[g+1] <= 1'b0;
				end else begin
					dl_user[g+1] <= dl_user[g];
					dl_chan[g+1] <= dl_chan[g];
					dl_last[g+1] <= dl_last[g];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// output packing
	wire [OB-1:0] sin_x = {{(OB-OUT_W){i_sine[OUT_W-1]}}, i_sine};
	wire [OB-1:0] cos_x = {{(OB-OUT_W){i_cosine[OUT_W-1]}}, i_cosine};
	wire [2*OB-1:0] nxt_dat =
		(osel == dds_framing_pkg::OSEL_QUAD) ? {sin_x, cos_x} :
		(osel == dds_framing_pkg::OSEL_SINE) ? {{OB{1'b0}}, sin_x} :
		{{OB{1'b0}}, cos_x};
	wire ph_fill = raster ? 1'b0 : i_phase_out[PHASE_W-1];
	wire [PB-1:0] nxt_pho = {{(PB-PHASE_W){ph_fill}}, i_phase_out};
	wire [USER_W-1:0] u_out = dl_user[LAT];
	wire [CW-1:0] c_out = dl_chan[LAT];

	// side-band layout, index lowest when present
	function automatic logic [TUW-1:0] pack_user(input logic uen, input logic cen,
		input logic [USER_W-1:0] u, input logic [CW-1:0] c);
		logic [TUW-1:0] r;
		r = '0;
		if (uen && cen) begin
			r = {u, c};
		end else if (uen) begin
			r = {{CW{1'b0}}, u};
		end else if (cen) begin
			r = {{USER_W{1'b0}}, c};
		end
		return r;
	endfunction

	wire [TUW-1:0] nxt_dat_user = pack_user(ctrl_ff[dds_framing_pkg::CTRL_DUSER_BIT],
		ctrl_ff[dds_framing_pkg::CTRL_DCHAN_BIT], u_out, c_out);
	wire [TUW-1:0] nxt_pho_user = pack_user(ctrl_ff[dds_framing_pkg::CTRL_PUSER_BIT],
		ctrl_ff[dds_framing_pkg::CTRL_PCHAN_BIT], u_out, c_out);

	// output stream registers
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_dat_tvalid <= 1'b0;
			o_dat_tlast <= 1'b0;
			o_dat_tdata <= '0;
			o_dat_tuser <= '0;
			o_pho_tvalid <= 1'b0;
			o_pho_tlast <= 1'b0;
			o_pho_tdata <= '0;
			o_pho_tuser <= '0;
		end else begin
			o_dat_tvalid <= i_dp_valid;
			o_dat_tlast <= i_dp_valid & dl_last[LAT];
			o_dat_tdata <= nxt_dat;
			o_dat_tuser <= nxt_dat_user;
			o_pho_tvalid <= i_dp_valid;
			o_pho_tlast <= i_dp_valid & dl_last[LAT];
			o_pho_tdata <= nxt_pho;
			o_pho_tuser <= nxt_pho_user;
		end
	end
endmodule

// File: rtl/dds_framing_pkg.sv
// constants for the synthesizer output framing and event block
package dds_framing_pkg;
	// register byte addresses
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] MODULUS_ADDR = 8'h04;
	localparam logic [7:0] STATUS_ADDR = 8'h08;
	// control field positions
	localparam int CTRL_OSEL_LSB = 0;
	localparam int CTRL_OFRAME_LSB = 2;
	localparam int CTRL_RASTER_BIT = 4;
	localparam int CTRL_DUSER_BIT = 5;
	localparam int CTRL_DCHAN_BIT = 6;
	localparam int CTRL_PUSER_BIT = 7;
	localparam int CTRL_PCHAN_BIT = 8;
	localparam int CTRL_ICHAN_BIT = 9;
	localparam int CTRL_IFRAME_LSB = 10;
	localparam int CTRL_LASTCH_LSB = 16;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] MODULUS_RESET = 32'h0000_0000;
	// status field positions
	localparam int STAT_CH_LSB = 0;
	localparam int STAT_CFGCH_LSB = 4;
	localparam int STAT_PEND_BIT = 8;
	localparam int STAT_EV_LSB = 16;
	// apb answer timing: cycles of access phase before pready
	localparam int APB_WAIT_CYCLES = 1;
	// output sample selection
	typedef enum logic [1:0] {
		OSEL_QUAD = 2'b00,
		OSEL_SINE = 2'b01,
		OSEL_COSINE = 2'b10
	} osel_type;
	// frame-end marker modes
	typedef enum logic [1:0] {
		FRAME_NONE = 2'b00,
		FRAME_VECTOR = 2'b01,
		FRAME_PACKET = 2'b10,
		FRAME_CONFIG = 2'b11
	} frame_type;
	// apb slave states
	typedef enum logic [0:0] {
		APB_IDLE = 1'b0,
		APB_DONE = 1'b1
	} apb_state_type;
endpackage

// File: bench/dds_framing_sva.sv
// port assertions for the output framing and event block
module dds_framing_sva #(
	parameter int PHASE_W = 11
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic o_pready,
	input wire logic i_cfg_tvalid,
	input wire logic i_cfg_tlast,
	input wire logic i_phs_tvalid,
	input wire logic i_phs_tlast,
	input wire logic i_dp_valid,
	input wire logic [PHASE_W-1:0] i_phase_out,
	input wire logic o_dat_tvalid,
	input wire logic o_dat_tlast,
	input wire logic o_pho_tvalid,
	input wire logic o_pho_tlast,
	input wire logic [((PHASE_W+7)/8)*8-1:0] o_pho_tdata,
	input wire logic o_ev_cfg_last_unexp,
	input wire logic o_ev_cfg_last_miss,
	input wire logic o_ev_phs_last_unexp,
	input wire logic o_ev_phs_last_miss,
	input wire logic o_ev_pinc_invalid,
	input wire logic o_ev_poff_invalid,
	input wire logic o_ev_chanid_wrong
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	// bus answer after one wait state, one cycle long
	a_pready_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready)
		else $error("pready timing wrong");
	// outputs follow the datapath by one register
	a_out_valid: assert property (o_dat_tvalid == $past(i_dp_valid) && o_pho_tvalid == o_dat_tvalid)
		else $error("output valid not aligned");
	a_pho_bits: assert property (o_pho_tvalid |-> o_pho_tdata[PHASE_W-1:0] == $past(i_phase_out))
		else $error("phase output bits wrong");
	a_last_valid: assert property (o_dat_tlast |-> o_dat_tvalid)
		else $error("frame end without valid");
	a_last_same: assert property (o_pho_tlast == o_dat_tlast)
		else $error("phase frame end differs");
	// events only the cycle after a matching input cycle
	a_cfg_unexp: assert property (o_ev_cfg_last_unexp |-> $past(i_cfg_tvalid && i_cfg_tlast))
		else $error("config early end without cause");
	a_cfg_miss: assert property (o_ev_cfg_last_miss |-> $past(i_cfg_tvalid && !i_cfg_tlast))
		else $error("config missing end without cause");
	a_phs_unexp: assert property (o_ev_phs_last_unexp |-> $past(i_phs_tvalid && i_phs_tlast))
		else $error("phase early end without cause");
	a_phs_miss: assert property (o_ev_phs_last_miss |-> $past(i_phs_tvalid && !i_phs_tlast))
		else $error("phase missing end without cause");
	a_range_ev: assert property (o_ev_pinc_invalid || o_ev_poff_invalid |-> $past(i_phs_tvalid || i_cfg_tvalid))
		else $error("range event without cause");
	a_chanid_ev: assert property (o_ev_chanid_wrong |-> $past(i_phs_tvalid))
		else $error("channel event without cause");
endmodule
bind dds_output_framing_events dds_framing_sva #(.PHASE_W(PHASE_W)) u_sva (.i_clk, .i_reset_n, .i_psel,
	.i_penable, .o_pready, .i_cfg_tvalid, .i_cfg_tlast, .i_phs_tvalid, .i_phs_tlast, .i_dp_valid,
	.i_phase_out, .o_dat_tvalid, .o_dat_tlast, .o_pho_tvalid, .o_pho_tlast, .o_pho_tdata,
	.o_ev_cfg_last_unexp, .o_ev_cfg_last_miss, .o_ev_phs_last_unexp, .o_ev_phs_last_miss,
	.o_ev_pinc_invalid, .o_ev_poff_invalid, .o_ev_chanid_wrong);

// File: bench/dds_dp_model.sv
// datapath model: sine, cosine and phase a fixed latency after the phase input
module dds_dp_model #(
	parameter int LAT = 4
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_vld,
	input wire logic [10:0] i_d,
	output logic o_vld,
	output logic [10:0] o_sin,
	output logic [10:0] o_cos,
	output logic [10:0] o_ph
);
	logic [LAT-1:0] v_ff;
	logic [10:0] d_ff [LAT];
	// delay line, results exactly lat cycles after the input transfer
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) v_ff <= '0;
		else v_ff <= {v_ff[LAT-2:0], i_vld};
	end
	always_ff @(posedge i_clk) begin
		d_ff[0] <= i_d;
		for (int k = 1; k < LAT; k++) d_ff[k] <= d_ff[k-1];
	end
	assign o_vld = v_ff[LAT-1];
	assign o_sin = d_ff[LAT-1];
	assign o_cos = ~d_ff[LAT-1];
	assign o_ph = d_ff[LAT-1];
endmodule

// File: bench/testbench.sv
// self-checking bench for the output framing and event block
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LAT = 4;
	typedef struct packed {logic [31:0] d; logic [15:0] p; logic [11:0] u; logic [11:0] pu; logic t;} exp_type;
	logic i_clk = 0, i_reset_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, se;
	logic [7:0] i_paddr = 0;
	logic [31:0] i_pwdata = 0, o_prdata, rd, i_cfg_tdata = 0, i_phs_tdata = 0, o_dat_tdata;
	logic o_pready, o_pslverr, i_cfg_tvalid = 0, i_cfg_tlast = 0, o_cfg_tready, o_cfg_apply;
	logic i_phs_tvalid = 0, i_phs_tlast = 0, i_dp_valid, o_dat_tvalid, o_dat_tlast, o_pho_tvalid, o_pho_tlast;
	logic [11:0] i_phs_tuser = 0, o_dat_tuser, o_pho_tuser;
	logic [10:0] i_sine, i_cosine, i_phase_out;
	logic [15:0] o_pho_tdata;
	logic o_ev_cfg_last_unexp, o_ev_cfg_last_miss, o_ev_phs_last_unexp, o_ev_phs_last_miss;
	logic o_ev_pinc_invalid, o_ev_poff_invalid, o_ev_chanid_wrong;
	logic [6:0] evs = 0;
	logic [1:0] osel = 0, ofr = 0, ifr = 1;
	logic ras = 0, due = 1, dce = 1, pue = 0, pce = 1, pend = 0;
	logic [3:0] last = 3;
	int err_count = 0, n_checks = 0, n_apply = 0;
	exp_type q[$], me;
	always #5 i_clk = ~i_clk;
	dds_output_framing_events #(.LAT(LAT)) u_dut (.i_clk, .i_reset_n, .i_psel, .i_penable, .i_pwrite,
		.i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_cfg_tvalid, .i_cfg_tlast, .i_cfg_tdata,
		.o_cfg_tready, .o_cfg_apply, .i_phs_tvalid, .i_phs_tlast, .i_phs_tdata, .i_phs_tuser, .i_dp_valid,
		.i_sine, .i_cosine, .i_phase_out, .o_dat_tvalid, .o_dat_tlast, .o_dat_tdata, .o_dat_tuser,
		.o_pho_tvalid, .o_pho_tlast, .o_pho_tdata, .o_pho_tuser, .o_ev_cfg_last_unexp, .o_ev_cfg_last_miss,
		.o_ev_phs_last_unexp, .o_ev_phs_last_miss, .o_ev_pinc_invalid, .o_ev_poff_invalid, .o_ev_chanid_wrong);
	dds_dp_model #(.LAT(LAT)) u_dp (.i_clk, .i_reset_n, .i_vld(i_phs_tvalid), .i_d(i_phs_tdata[10:0]),
		.o_vld(i_dp_valid), .o_sin(i_sine), .o_cos(i_cosine), .o_ph(i_phase_out));
	////////////////////////////////////////////////////////////////////////
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	// one apb transfer, held until pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge i_clk);
		i_psel <= 1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= wd;
		@(posedge i_clk);
		i_penable <= 1;
		n = 0;
		// pready, read data and error taken at the rising edge that completes
		do begin
			@(posedge i_clk);
			n++;
		end while (o_pready !== 1'b1 && n < 20);
		if (o_pready !== 1'b1) chk("pready", 1, 0);
		rd = o_prdata;
		se = o_pslverr;
		i_psel <= 0;
		i_penable <= 0;
	endtask
	// control word from the current scenario settings
	function automatic logic [31:0] cw();
		return {12'h0, last, 4'h0, ifr, 1'b1, pce, pue, dce, due, ras, ofr, osel};
	endfunction
	task setc();
		apb(1, dds_framing_pkg::CTRL_ADDR, cw());
	endtask
	function automatic logic [15:0] sx(input logic [10:0] x);
		return {{5{x[10]}}, x};
	endfunction
	function automatic logic [11:0] tu(input logic ue, input logic ce, input logic [3:0] c);
		return ue && ce ? {~c, c, c} : ue ? {4'h0, ~c, c} : {8'h0, c};
	endfunction
	// one phase transfer and the output it should produce
	task send(input logic [3:0] c, input logic tl, input logic [3:0] id, input logic [10:0] d,
		input logic [10:0] o);
		exp_type e;
		@(posedge i_clk);
		i_phs_tvalid <= 1;
		i_phs_tlast <= tl;
		i_phs_tdata <= {5'h0, o, 5'h0, d};
		i_phs_tuser <= {~c, c, id};
		e.d = osel == 2'd0 ? {sx(d), sx(~d)} : {16'h0, sx(osel == 2'd1 ? d : ~d)};
		e.p = ras ? {5'h0, d} : sx(d);
		e.u = tu(due, dce, c);
		e.pu = tu(pue, pce, c);
		e.t = ofr == 2'd1 ? c == last : ofr == 2'd2 ? tl : ofr == 2'd3 && c == last && pend;
		if (c == last) pend = 0;
		q.push_back(e);
	endtask
	task vec(input int tlp, input int bad, input logic [10:0] d, input logic [10:0] o);
		for (int k = 0; k <= last; k++) send(k[3:0], k == tlp, k == bad ? ~k[3:0] : k[3:0], d + k[10:0], o);
		@(posedge i_clk);
		i_phs_tvalid <= 0;
	endtask
	// config vector of n transfers, in-range zero values
	task cvec(input int n, input int tlp);
		for (int k = 0; k < n; k++) begin
			@(posedge i_clk);
			i_cfg_tvalid <= 1;
			i_cfg_tlast <= k == tlp;
		end
		@(posedge i_clk);
		i_cfg_tvalid <= 0;
		i_cfg_tlast <= 0;
	endtask
	task evk(input logic [6:0] e);
		repeat (LAT + 3) @(posedge i_clk);
		chk("events", e, evs);
		chk("drained", 0, q.size());
		evs = 0;
	endtask
	// output monitor and event collector
	always @(negedge i_clk) if (i_reset_n) begin
		evs = evs | {o_ev_cfg_last_unexp, o_ev_cfg_last_miss, o_ev_phs_last_unexp, o_ev_phs_last_miss,
			o_ev_pinc_invalid, o_ev_poff_invalid, o_ev_chanid_wrong};
		if (o_cfg_apply === 1'b1) n_apply++;
		if (o_dat_tvalid === 1'b1 && q.size() == 0) chk("extra output", 0, 1);
		else if (o_dat_tvalid === 1'b1) begin
			me = q.pop_front();
			chk("dat data", me.d, o_dat_tdata);
			chk("dat last", me.t, o_dat_tlast);
			chk("pho last", me.t, o_pho_tlast);
			chk("dat user", me.u, o_dat_tuser);
			chk("pho user", me.pu, o_pho_tuser);
			chk("pho data", me.p, o_pho_tdata);
		end
	end
	task tally_and_finish();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		#50000;
		chk("timeout", 0, 1);
		tally_and_finish();
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		i_reset_n = 0;
		repeat (2) @(posedge i_clk);
		chk("reset outputs", 0, {o_cfg_tready, o_cfg_apply, o_pready, o_dat_tvalid, evs,
			o_ev_cfg_last_miss, o_ev_chanid_wrong});
		i_reset_n <= 1;
		apb(0, dds_framing_pkg::CTRL_ADDR, 0);
		chk("ctrl reset", dds_framing_pkg::CTRL_RESET, rd);
		apb(0, dds_framing_pkg::STATUS_ADDR, 0);
		chk("status reset", 0, rd);
		apb(0, 8'h0c, 0);
		chk("unmapped data", 0, rd);
		chk("unmapped error", 1, se);
		chk("cfg ready", 1, o_cfg_tready);
		// every output select with vector framing
		ofr = 1;
		for (int k = 0; k < 3; k++) begin
			osel = k[1:0];
			setc();
			vec(3, 9, 11'h3fe, 0);
			evk(0);
		end
		// packet framing, user field only on both side-band outputs
		osel = 0; ofr = 2; ifr = 2; dce = 0; pue = 1; pce = 0;
		setc();
		apb(0, dds_framing_pkg::CTRL_ADDR, 0);
		chk("ctrl readback", cw(), rd);
		vec(1, 9, 11'h7f0, 0);
		evk(0);
		// phase framing and channel id faults
		ofr = 0; ifr = 1;
		setc();
		vec(1, 2, 11'h10, 0);
		evk(7'b0011001);
		// rasterized range checks
		ras = 1;
		apb(1, dds_framing_pkg::MODULUS_ADDR, 32'h0000_0064);
		apb(0, dds_framing_pkg::MODULUS_ADDR, 0);
		chk("modulus readback", 32'h0000_0064, rd);
		setc();
		vec(3, 9, 11'd10, 11'd5);
		evk(0);
		vec(3, 9, 11'h500, 11'd5);
		evk(7'b0000100);
		vec(3, 9, 11'd10, 11'd200);
		evk(7'b0000010);
		ras = 0;
		// config framing faults, then a good vector and its frame end
		cvec(2, 1);
		evk(7'b1000000);
		cvec(4, 9);
		evk(7'b0100000);
		apb(0, dds_framing_pkg::STATUS_ADDR, 0);
		chk("status pending", 32'h0000_0100, rd);
		cvec(4, 3);
		evk(0);
		pend = 1;
		ofr = 3;
		setc();
		vec(3, 9, 11'd1, 0);
		vec(3, 9, 11'd2, 0);
		evk(0);
		chk("apply pulses", 1, n_apply);
		// sixteen channels in rotation
		last = 15; ofr = 1; dce = 1;
		setc();
		vec(15, 99, 11'h3f8, 0);
		evk(0);
		tally_and_finish();
	end
endmodule
